// ---- spx_ext_cfg.sv ----
`include "spx_map.svh"
`default_nettype none
module spx_ext_cfg #(
    parameter logic [7:0] LOCAL_CLOCK_NS = 8'h00
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Error events from the port, one-cycle pulses
    input wire logic uncorr_err_i,
    input wire logic err_nonfatal_i,
    input wire logic err_fatal_i,
    input wire logic [15:0] err_requester_i,
    // Power state from the link logic
    input wire logic l11_enter_i,
    input wire logic l11_exit_i,
    // Shared open-drain clock request
    input wire logic clock_request_n_i,
    output logic clock_request_n_o,
    output logic clock_request_n_oe_o,
    // Status to the port
    output logic l11_active_o,
    output logic time_meas_active_o,
    output logic time_meas_root_o,
    output logic containment_active_o,
    output logic irq_o
);
    import spx_pkg::*;

    localparam int TICK = `SPX_WAIT_TICK;

    logic containment_triggered_flag_r;
    logic [1:0] containment_cause_r;
    logic containment_irq_flag_r;
    logic [15:0] containment_source_requester_r;
    logic [1:0] containment_trigger_select_r;
    logic containment_irq_enable_r;
    logic time_meas_enable_r;
    logic root_select_r;
    logic [7:0] eff_gran_r;
    logic [19:0] release_wait_interval_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic req_sync1_r;
    logic req_sync2_r;
    spx_clk_state_type clk_state_r;
    logic [19:0] wait_cnt_r;
    logic [7:0] tick_cnt_r;

    wire wr = psel_i && penable_i && pwrite_i;
    wire rd_phase = psel_i && penable_i && !pwrite_i;
    wire wr_cstat = wr && paddr_i == `SPX_OFF_CSTAT;
    wire wr_ctl = wr && paddr_i == `SPX_OFF_TM_CTL;
    wire wr_wait = wr && paddr_i == `SPX_OFF_WAIT;
    wire wr_cctl = wr && paddr_i == `SPX_OFF_CCTL;
    wire wr_ien = wr && paddr_i == `SPX_OFF_IRQ_EN;
    wire wr_iclr = wr && paddr_i == `SPX_OFF_IRQ_CLR;

    // Trigger decision by select field
    logic trig;
    logic [1:0] trig_cause;
    always_comb begin
        trig = 1'b0;
        trig_cause = `SPX_CAUSE_UNCORR;
        case (containment_trigger_select_r) // see [R15]
            2'b01: begin
                trig = uncorr_err_i || err_fatal_i;
                trig_cause = uncorr_err_i ? `SPX_CAUSE_UNCORR : `SPX_CAUSE_FATAL;
            end
            2'b10: begin
                trig = uncorr_err_i || err_fatal_i || err_nonfatal_i;
                if (uncorr_err_i) begin
                    trig_cause = `SPX_CAUSE_UNCORR;
                end else if (err_fatal_i) begin
                    trig_cause = `SPX_CAUSE_FATAL;
                end else begin
                    trig_cause = `SPX_CAUSE_NONFATAL;
                end
            end
            default: begin
                trig = 1'b0;
                trig_cause = `SPX_CAUSE_UNCORR;
            end
        endcase
    end

    // Only the first event is logged; a new one lands after the flag clears
    wire log_new = trig && !containment_triggered_flag_r; // see [R17]

    // Set wins over a simultaneous clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            containment_triggered_flag_r <= 1'b0;
        end else if (trig) begin
            containment_triggered_flag_r <= 1'b1; // see [R1]
        end else if (wr_cstat && pwdata_i[0]) begin
            containment_triggered_flag_r <= 1'b0; // see [R1]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            containment_cause_r <= 2'h0;
            containment_source_requester_r <= 16'h0000;
        end else if (log_new) begin
            containment_cause_r <= trig_cause; // see [R2]
            if (trig_cause != `SPX_CAUSE_UNCORR) begin
                containment_source_requester_r <= err_requester_i; // see [R4]
            end
        end else if (wr_cstat) begin
            containment_cause_r <= containment_cause_r & ~pwdata_i[2:1]; // see [R2]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            containment_irq_flag_r <= 1'b0;
        end else if (trig && containment_irq_enable_r) begin
            containment_irq_flag_r <= 1'b1; // see [R3]
        end else if (wr_cstat && pwdata_i[3]) begin
            containment_irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            containment_trigger_select_r <= 2'h0;
            containment_irq_enable_r <= 1'b0;
        end else if (wr_cctl) begin
            containment_trigger_select_r <= pwdata_i[17:16];
            containment_irq_enable_r <= pwdata_i[`SPX_BIT_IRQ_EN];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            time_meas_enable_r <= 1'b0;
            root_select_r <= 1'b0;
            eff_gran_r <= 8'h00;
        end else if (wr_ctl) begin
            time_meas_enable_r <= pwdata_i[0];
            root_select_r <= pwdata_i[1];
            eff_gran_r <= pwdata_i[15:8]; // see [R10]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            release_wait_interval_r <= `SPX_WAIT_RST; // see [R14]
        end else if (wr_wait) begin
            release_wait_interval_r <= pwdata_i[19:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            time_meas_active_o <= 1'b0;
            time_meas_root_o <= 1'b0;
            containment_active_o <= 1'b0;
        end else begin
            time_meas_active_o <= time_meas_enable_r; // see [R8]
            time_meas_root_o <= time_meas_enable_r && root_select_r; // see [R9]
            containment_active_o <= containment_triggered_flag_r;
        end
    end

    // Line level sampled through two flops
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            req_sync1_r <= 1'b0;
            req_sync2_r <= 1'b0;
        end else begin
            req_sync1_r <= clock_request_n_i;
            req_sync2_r <= req_sync1_r; // see [R12]
        end
    end

    // Clock request handshake
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            clk_state_r <= SPX_ACTIVE;
            wait_cnt_r <= 20'h00000;
            tick_cnt_r <= 8'h00;
        end else begin
            case (clk_state_r)
                SPX_ACTIVE: begin
                    if (l11_enter_i) begin
                        clk_state_r <= SPX_WAIT; // see [R11]
                        wait_cnt_r <= 20'h00000; // see [R19]
                        tick_cnt_r <= 8'h00;
                    end
                end
                SPX_WAIT: begin
                    if (req_sync2_r) begin
                        clk_state_r <= SPX_L11; // see [R19]
                    end else if (wait_cnt_r >= release_wait_interval_r) begin
                        clk_state_r <= SPX_ACTIVE; // see [R13]
                    end else if (tick_cnt_r == 8'(TICK - 1)) begin
                        tick_cnt_r <= 8'h00;
                        wait_cnt_r <= wait_cnt_r + 20'h00001; // see [R14]
                    end else begin
                        tick_cnt_r <= tick_cnt_r + 8'h01;
                    end
                end
                SPX_L11: begin
                    if (l11_exit_i) begin
                        clk_state_r <= SPX_ACTIVE;
                    end
                end
                default: clk_state_r <= SPX_ACTIVE;
            endcase
        end
    end

    // Open drain: drive low only, release by dropping enable
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            clock_request_n_oe_o <= 1'b1;
            l11_active_o <= 1'b0;
        end else begin
            // Partner release at the deadline still wins, so no pull glitch on L1.1 entry
            clock_request_n_oe_o <= !(l11_enter_i && clk_state_r == SPX_ACTIVE) &&
                                    !(clk_state_r == SPX_WAIT &&
                                      (req_sync2_r || wait_cnt_r < release_wait_interval_r)) &&
                                    !(clk_state_r == SPX_L11 && !l11_exit_i); // see [R11]
            l11_active_o <= clk_state_r == SPX_L11;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            clock_request_n_o <= 1'b0;
        end else begin
            clock_request_n_o <= 1'b0; // see [R12]
        end
    end

    // Interrupt status: bit0 containment trigger, bit1 clock request timeout
    wire timeout_ev = clk_state_r == SPX_WAIT && !req_sync2_r && wait_cnt_r >= release_wait_interval_r;
    wire [1:0] ev = {timeout_ev, containment_irq_flag_r && containment_irq_enable_r}; // see [R16]
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_stat_r <= 2'h0;
            irq_en_r <= 2'h0;
        end else begin
            irq_stat_r <= ev | (irq_stat_r & ~(wr_iclr ? pwdata_i[1:0] : 2'h0));
            if (wr_ien) begin
                irq_en_r <= pwdata_i[1:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((ev | irq_stat_r) & irq_en_r);
        end
    end

    // Read mux; reserved bits read zero
    logic [31:0] rdata;
    logic hit;
    always_comb begin
        rdata = 32'h00000000;
        hit = 1'b1;
        case (paddr_i)
            `SPX_OFF_CSTAT: rdata = {containment_source_requester_r, 12'h000, containment_irq_flag_r,
                                      containment_cause_r, containment_triggered_flag_r}; // see [R18]
            `SPX_OFF_TM_HDR: rdata = `SPX_TM_HDR_VAL; // see [R5]
            `SPX_OFF_TM_CAP: rdata = {16'h0000, LOCAL_CLOCK_NS, 5'h00, `SPX_TM_CAP_ROLES}; // see [R6] see [R7]
            `SPX_OFF_TM_CTL: rdata = {16'h0000, eff_gran_r, 6'h00, root_select_r, time_meas_enable_r};
            `SPX_OFF_WAIT: rdata = {12'h000, release_wait_interval_r};
            `SPX_OFF_CCTL: rdata = {12'h000, containment_irq_enable_r, 1'b0, containment_trigger_select_r, 16'h0000};
            `SPX_OFF_IRQ_STAT: rdata = {30'h00000000, irq_stat_r};
            `SPX_OFF_IRQ_EN: rdata = {30'h00000000, irq_en_r};
            `SPX_OFF_IRQ_CLR: rdata = 32'h00000000;
            default: hit = 1'b0;
        endcase
    end

    // Answer in the first access cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit;
            prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rdata : 32'h00000000;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_phase;
endmodule
`default_nettype wire

// ---- spx_ext_cfg_chk.sv ----
`default_nettype none
module spx_ext_cfg_chk #(
    parameter logic [7:0] LOCAL_CLOCK_NS = 8'h00
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    // Events and link state
    input wire logic uncorr_err_i,
    input wire logic err_nonfatal_i,
    input wire logic err_fatal_i,
    input wire logic l11_enter_i,
    input wire logic clock_request_n_o,
    input wire logic clock_request_n_oe_o,
    input wire logic l11_active_o,
    input wire logic time_meas_active_o,
    input wire logic containment_active_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Only holds while the wait interval stays small
    localparam int MAX_WAIT = 40;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_rd(logic [11:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a;
    endsequence
    sequence s_wr(logic [11:0] a);
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
    endsequence
    sequence s_quiet;
        !uncorr_err_i && !err_nonfatal_i && !err_fatal_i;
    endsequence
    property p_hdr;
        s_rd(12'h260) |=> prdata_o == 32'h0001001f;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad header");
    property p_cap;
        s_rd(12'h264) |=> prdata_o == {16'h0, LOCAL_CLOCK_NS, 8'h07};
    endproperty
    a_cap: assert property (p_cap) else $error("bad capability");
    property p_tm_act;
        s_wr(12'h268) |=> ##1 time_meas_active_o == $past(pwdata_i[0], 2);
    endproperty
    a_tm_act: assert property (p_tm_act) else $error("bad enable");
    property p_trig_clr;
        s_wr(12'h258) ##0 pwdata_i[0] ##0 s_quiet ##1 s_quiet |=> !containment_active_o;
    endproperty
    a_trig_clr: assert property (p_trig_clr) else $error("flag kept");
    property p_release;
        l11_enter_i && clock_request_n_oe_o && !l11_active_o |=> !clock_request_n_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_drive_low;
        !clock_request_n_o;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("drives high");
    property p_wait_bound;
        $fell(clock_request_n_oe_o) |-> ##[1:MAX_WAIT] (clock_request_n_oe_o || l11_active_o);
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("wait stuck");
    property p_l11_quiet;
        $rose(l11_active_o) |-> !clock_request_n_oe_o;
    endproperty
    a_l11_quiet: assert property (p_l11_quiet) else $error("driving in L1.1");
endmodule
`default_nettype wire

// ---- spx_link_partner.sv ----
`default_nettype none
module spx_link_partner (
    // Clock
    input wire logic core_clk_i,
    // Bench control
    input wire logic hold_i,
    input wire logic [3:0] lag_i,
    // Shared line
    input wire logic dev_oe_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pull_r;
    logic [3:0] cnt_r;
    // Lets go only lag_i cycles after the bench stops holding
    always @(posedge core_clk_i) begin
        if (hold_i) begin
            pull_r <= 1'b1;
            cnt_r <= lag_i;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            pull_r <= 1'b0;
        end
    end
    // Pull-up: released by both means high
    assign line_o = !(dev_oe_i || pull_r);
endmodule
`default_nettype wire

// ---- spx_map.svh ----
// Function
// [R1] Trigger flag bit0 set on containment, W1C
// [R2] Cause bits 2:1 recorded, W1C
// [R3] Irq flag bit3 set only when enabled
// [R4] Capture requester ID for message causes
// [R5] Capability header reads 001Fh, v1, next 000h
// [R6] Capability bits 0..2 read one
// [R7] Clock period field bits 15:8, reset 00h
// [R8] Time measurement active only when enabled
// [R9] Root role needs root select and enable
// [R10] Granularity field is plain storage
// [R11] Release clock request at L1.1 entry
// [R12] Sense shared line level, drive low only
// [R13] Timeout reasserts request, back to L1
// [R14] Wait counts 10 ns units, reset 0FFFh
// [R15] Trigger select gates which errors trigger
// [R16] Interrupt only while irq enable set
// [R17] First logged cause and source are kept
// [R18] Reserved bits read zero, ignore writes
// [R19] Wait timer starts at release, stops on release
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH
`define SPX_OFF_CSTAT 12'h258
`define SPX_OFF_TM_HDR 12'h260
`define SPX_OFF_TM_CAP 12'h264
`define SPX_OFF_TM_CTL 12'h268
`define SPX_OFF_WAIT 12'h300
`define SPX_OFF_CCTL 12'h270
`define SPX_OFF_IRQ_STAT 12'h280
`define SPX_OFF_IRQ_EN 12'h284
`define SPX_OFF_IRQ_CLR 12'h288
`define SPX_TM_HDR_VAL 32'h0001001f
`define SPX_TM_CAP_ROLES 3'h7
`define SPX_WAIT_RST 20'h00fff
`define SPX_WAIT_UNIT_NS 10
`define SPX_CLK_NS 5
`define SPX_WAIT_TICK ((`SPX_WAIT_UNIT_NS + `SPX_CLK_NS - 1) / `SPX_CLK_NS)
`define SPX_BIT_IRQ_EN 19
`define SPX_CAUSE_UNCORR 2'h0
`define SPX_CAUSE_NONFATAL 2'h1
`define SPX_CAUSE_FATAL 2'h2
`endif

// ---- spx_pkg.sv ----
`default_nettype none
package spx_pkg;
    typedef enum logic [1:0] {
        SPX_ACTIVE = 2'b00,
        SPX_WAIT = 2'b01,
        SPX_L11 = 2'b10
    } spx_clk_state_type;
endpackage
`default_nettype wire

// ---- tb_spx_ext_cfg.sv ----
`default_nettype none
module tb_spx_ext_cfg;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] LCN = 8'h05;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, unc = 0, nfe = 0, fte = 0, ent = 0, ext = 0, hold = 1;
    logic [11:0] addr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [15:0] rid = 0;
    logic [3:0] lag = 0;
    logic rdy, err, line, oe, l11, tma, tmr, cact, irq;
    logic [32:0] exp_q[$];
    int bad_count = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    spx_ext_cfg #(.LOCAL_CLOCK_NS(LCN)) uut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err),
        .uncorr_err_i(unc), .err_nonfatal_i(nfe), .err_fatal_i(fte), .err_requester_i(rid), .l11_enter_i(ent),
        .l11_exit_i(ext), .clock_request_n_i(line), .clock_request_n_o(), .clock_request_n_oe_o(oe),
        .l11_active_o(l11), .time_meas_active_o(tma), .time_meas_root_o(tmr), .containment_active_o(cact),
        .irq_o(irq));
    spx_link_partner u_lp (.core_clk_i(clk), .hold_i(hold), .lag_i(lag), .dev_oe_i(oe), .line_o(line));
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task chkb(input logic seen, input logic want);
        chk({32'h0, seen}, {32'h0, want});
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!rdy && n < 20);
        chkb(rdy, 1'b1);
        if (!rdy) tally_and_finish();
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task ev(input int k, input logic [15:0] id);
        @(posedge clk);
        unc <= k == 0;
        nfe <= k == 1;
        fte <= k == 2;
        rid <= id;
        @(posedge clk);
        unc <= 1'b0;
        nfe <= 1'b0;
        fte <= 1'b0;
    endtask
    // Read data checked in the access cycle, oldest note first
    always @(posedge clk) begin
        if (psel && pen && rdy && !pwr && exp_q.size() > 0) chk({err, rdat}, exp_q.pop_front());
    end
    initial begin
        int s, k, r, n;
        logic en, tr;
        logic [15:0] id, src;
        logic [31:0] v;
        void'($urandom(32'h1758));
        src = 16'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1, 12'h264, 32'hffffffff, 33'h0);
        apb(0, 12'h258, 0, 33'h0);
        apb(0, 12'h260, 0, 33'h0001001f);
        apb(0, 12'h264, 0, {17'h0, LCN, 8'h07});
        apb(0, 12'h300, 0, 33'h00fff);
        apb(1, 12'h300, 32'hffffffff, 33'h0);
        apb(0, 12'h300, 0, 33'hfffff);
        apb(0, 12'h2fc, 0, {1'b1, 32'h0});
        for (r = 0; r < 4; r++) begin
            v = $urandom;
            apb(1, 12'h268, v, 33'h0);
            apb(0, 12'h268, 0, {17'h0, v[15:8], 6'h0, v[1:0]});
            chkb(tma, v[0]);
            chkb(tmr, v[0] & v[1]);
        end
        $display("test registers done");
        apb(1, 12'h284, 32'h1, 33'h0);
        for (s = 0; s < 3; s++) begin
            for (k = 0; k < 3; k++) begin
                en = 1'($urandom % 2);
                id = 16'($urandom);
                tr = (s == 2) || (s == 1 && k != 1);
                apb(1, 12'h270, {12'h0, en, 1'b0, 2'(s), 16'h0}, 33'h0);
                ev(k, id);
                if (tr && k != 0) src = id;
                for (r = 0; r < 2; r++) begin
                    if (r == 1 && tr) ev(2, ~id);
                    apb(0, 12'h258, 0, {1'b0, src, 12'h0, tr & en, tr ? 2'(k) : 2'h0, tr});
                end
                chkb(cact, tr);
                chkb(irq, tr & en);
                apb(1, 12'h258, 32'hf, 33'h0);
                apb(1, 12'h288, 32'h1, 33'h0);
            end
        end
        $display("test containment done");
        apb(1, 12'h300, 32'h8, 33'h0);
        for (r = 0; r < 3; r++) begin
            lag <= 4'($urandom % 6);
            @(posedge clk);
            ent <= 1'b1;
            hold <= 1'b0;
            @(posedge clk);
            ent <= 1'b0;
            n = 0;
            while (!l11 && n < 30) begin
                @(posedge clk);
                n++;
            end
            chkb(l11, 1'b1);
            if (!l11) tally_and_finish();
            chkb(oe, 1'b0);
            @(posedge clk);
            ext <= 1'b1;
            hold <= 1'b1;
            @(posedge clk);
            ext <= 1'b0;
            @(posedge clk);
            chkb(oe, 1'b1);
        end
        // Partner never lets go, so the wait must expire
        @(posedge clk);
        ent <= 1'b1;
        @(posedge clk);
        ent <= 1'b0;
        @(posedge clk);
        n = 0;
        while (!oe && n < 40) begin
            @(posedge clk);
            n++;
        end
        chkb(oe, 1'b1);
        if (!oe) tally_and_finish();
        chkb(n >= 14 && n <= 19, 1'b1);
        chkb(l11, 1'b0);
        apb(0, 12'h280, 0, 33'h2);
        chkb(irq, 1'b0);
        apb(1, 12'h284, 32'h3, 33'h0);
        repeat (4) @(posedge clk);
        chkb(irq, 1'b1);
        apb(1, 12'h288, 32'h2, 33'h0);
        repeat (4) @(posedge clk);
        chkb(irq, 1'b0);
        $display("test clock request done");
        tally_and_finish();
    end
endmodule
bind spx_ext_cfg spx_ext_cfg_chk #(.LOCAL_CLOCK_NS(LOCAL_CLOCK_NS)) u_chk (.core_clk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .uncorr_err_i, .err_nonfatal_i,
    .err_fatal_i, .l11_enter_i, .clock_request_n_o, .clock_request_n_oe_o, .l11_active_o, .time_meas_active_o,
    .containment_active_o);
`default_nettype wire
